// [design/capture_pkg.sv]
/*
 Shared constants for the serial receive pulse width capture unit and its
 polling controller. Assumes a single 10 MHz clock with synchronous reset.
*/
package capture_pkg;
	localparam int          COUNT_WIDTH     = 24;
	localparam logic [1:0]  SEL_NONE        = 2'h0;
	localparam logic [1:0]  SEL_RX_FIRST    = 2'h1;
	localparam logic [1:0]  EDGE_OFF        = 2'h0;
	localparam logic [1:0]  EDGE_RISING     = 2'h1;
	localparam logic [1:0]  EDGE_FALLING    = 2'h2;
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          TICK_HZ         = 10_000;
	localparam int          TICK_CYCLES     = CLK_HZ / TICK_HZ;
	localparam logic [23:0] COUNT_RESET     = 24'h00_0000;
	// Wishbone register offsets of the controller
	localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
	localparam logic [3:0]  ADDR_WIDTH      = 4'h4;
	localparam logic [3:0]  ADDR_STATUS     = 4'h8;
	localparam logic [3:0]  ADDR_CLEAR      = 4'hc;
	// Field positions
	localparam int          CTRL_ENABLE_BIT = 0;
	localparam int          ST_PULSE_BIT    = 0;
	localparam int          ST_REJECT_BIT   = 1;
	localparam int          ST_BITS         = 2;
	localparam logic [1:0]  ST_RESET        = 2'h0;
	localparam int          MIN_BITS        = 1;
	localparam int          MAX_BITS        = 4;
	localparam logic [23:0] BIT_TIME_RESET  = 24'h00_0800;
	typedef enum logic [1:0] {
		POLL_IDLE,
		POLL_FLAG,
		POLL_DATA
	} poll_state_type;
endpackage : capture_pkg

// [design/capture_if.sv]
/*
 Register port between the capture unit and its polling controller.
 Assumes both ends share one clock; reads act in the cycle rd is high.
*/
`timescale 1ns/1ps
interface capture_if;
	logic        ctrl_we;
	logic [1:0]  sel_wdata;
	logic [1:0]  edge_wdata;
	logic        flag_rd;
	logic        flag_rdata;
	logic        data_rd;
	logic [23:0] data_rdata;
	modport unit (
		input  ctrl_we, sel_wdata, edge_wdata, flag_rd, data_rd,
		output flag_rdata, data_rdata
	);
	modport ctrl (
		output ctrl_we, sel_wdata, edge_wdata, flag_rd, data_rd,
		input  flag_rdata, data_rdata
	);
endinterface : capture_if

// [design/capture_unit.sv]
/*
 Capture unit: free-running 24-bit counter with edge capture on the first
 serial receive pin. Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
module capture_unit
	import capture_pkg::*;
#(
	parameter int WIDTH = COUNT_WIDTH
) (
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   serial_rx_pin_first,
	capture_if.unit     port_if
);
	logic [WIDTH-1:0] count_reg;
	logic [1:0]       sync_reg;
	logic             rx_last_reg;
	logic [1:0]       capture_input_select;
	logic [1:0]       edge_select;
	logic             capture_event_flag;
	logic [WIDTH-1:0] captured_count;
	logic             fall;
	logic             rise;
	logic             hit;

	// Two flops before any logic looks at the pin
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_reg    <= 2'h3;
			rx_last_reg <= 1'b1;
		end else begin
			sync_reg    <= {sync_reg[0], serial_rx_pin_first};
			rx_last_reg <= sync_reg[1];
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			count_reg <= WIDTH'(COUNT_RESET);
		else
			count_reg <= count_reg + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			capture_input_select <= SEL_NONE;
			edge_select          <= EDGE_OFF;
		end else if (port_if.ctrl_we) begin
			capture_input_select <= port_if.sel_wdata;
			edge_select          <= port_if.edge_wdata;
		end
	end

	assign fall = rx_last_reg & ~sync_reg[1];
	assign rise = ~rx_last_reg & sync_reg[1];
	// Only the capture path exists; no compare hardware
	assign hit = (capture_input_select == SEL_RX_FIRST) &&
		((edge_select == EDGE_FALLING && fall) || (edge_select == EDGE_RISING && rise));

	// Capture wins over a read clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			captured_count     <= WIDTH'(COUNT_RESET);
			capture_event_flag <= 1'b0;
		end else begin
			if (hit)
				captured_count <= count_reg;
			else if (port_if.data_rd)
				captured_count <= WIDTH'(COUNT_RESET);
			if (hit)
				capture_event_flag <= 1'b1;
			else if (port_if.flag_rd)
				capture_event_flag <= 1'b0;
		end
	end

	assign port_if.flag_rdata = capture_event_flag;
	assign port_if.data_rdata = captured_count;
endmodule : capture_unit

// [design/capture_ctrl.sv]
/*
 Polling controller: measures low pulse widths through the capture unit and
 reports them over a classic Wishbone slave. Assumes one 10 MHz clock.
*/
`timescale 1ns/1ps
module capture_ctrl
	import capture_pkg::*;
#(
	parameter int TICK = TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	capture_if.ctrl          port_if,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq
);
	logic [15:0]       tick_reg;
	logic              enable_reg;
	logic              second_reg;
	logic [23:0]       first_reg;
	logic [23:0]       width_reg;
	logic [23:0]       bit_time_reg;
	logic [ST_BITS-1:0] status_reg;
	logic [ST_BITS-1:0] irq_en_reg;
	logic [ST_BITS-1:0] ev_pulse;
	logic [ST_BITS-1:0] clr;
	poll_state_type    state_reg;
	logic [23:0]       diff;
	logic              ok;
	logic              wb_hit;

	// Width of n bits lies between n-0.5 and n+0.5 bit times
	function automatic logic in_range(input logic [23:0] w, input logic [23:0] bt);
		logic r;
		r = 1'b0;
		for (int n = MIN_BITS; n <= MAX_BITS; n++)
			if ({8'h00, w} * 2 >= (2 * n - 1) * {8'h00, bt} && {8'h00, w} * 2 < (2 * n + 1) * {8'h00, bt})
				r = 1'b1;
		return r;
	endfunction : in_range

	assign diff = port_if.data_rdata - first_reg;
	assign ok   = in_range(diff, bit_time_reg);
	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign clr = (wb_hit && wb_we_i && wb_adr_i == ADDR_CLEAR && wb_sel_i[0]) ? wb_dat_i[ST_BITS-1:0] : '0;

	always_ff @(posedge clk) begin
		if (rst || tick_reg == 16'(TICK - 1))
			tick_reg <= 16'h0000;
		else
			tick_reg <= tick_reg + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg          <= POLL_IDLE;
			second_reg         <= 1'b0;
			first_reg          <= 24'h00_0000;
			width_reg          <= 24'h00_0000;
			bit_time_reg       <= BIT_TIME_RESET;
			ev_pulse           <= '0;
			port_if.ctrl_we    <= 1'b0;
			port_if.sel_wdata  <= SEL_NONE;
			port_if.edge_wdata <= EDGE_OFF;
			port_if.flag_rd    <= 1'b0;
			port_if.data_rd    <= 1'b0;
		end else begin
			ev_pulse        <= '0;
			port_if.ctrl_we <= 1'b0;
			port_if.flag_rd <= 1'b0;
			port_if.data_rd <= 1'b0;
			unique case (state_reg)
				POLL_IDLE: begin
					if (!enable_reg) begin
						if (port_if.sel_wdata != SEL_NONE) begin
							port_if.ctrl_we   <= 1'b1;
							port_if.sel_wdata <= SEL_NONE;
						end
						second_reg <= 1'b0;
					end else if (port_if.sel_wdata != SEL_RX_FIRST) begin
						port_if.ctrl_we    <= 1'b1;
						port_if.sel_wdata  <= SEL_RX_FIRST;
						port_if.edge_wdata <= EDGE_FALLING;
					end else if (tick_reg == 16'h0000) begin
						port_if.flag_rd <= 1'b1;
						state_reg       <= POLL_FLAG;
					end
				end
				POLL_FLAG: begin
					// Flag sampled in the same cycle as its read strobe, before the clear lands
					if (port_if.flag_rdata) begin
						port_if.data_rd <= 1'b1;
						state_reg       <= POLL_DATA;
					end else
						state_reg <= POLL_IDLE;
				end
				POLL_DATA: begin
					port_if.ctrl_we <= 1'b1;
					state_reg       <= POLL_IDLE;
					if (!second_reg) begin
						first_reg          <= port_if.data_rdata;
						port_if.edge_wdata <= EDGE_RISING;
						second_reg         <= 1'b1;
					end else begin
						width_reg          <= diff;
						port_if.edge_wdata <= EDGE_FALLING;
						second_reg         <= 1'b0;
						ev_pulse[ST_PULSE_BIT]  <= ok;
						ev_pulse[ST_REJECT_BIT] <= ~ok;
						if (ok && diff < bit_time_reg)
							bit_time_reg <= diff;
					end
				end
			endcase
		end
	end

	// Set wins over clear
	always_ff @(posedge clk) begin
		if (rst)
			status_reg <= ST_RESET;
		else
			status_reg <= (status_reg & ~clr) | ev_pulse;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			enable_reg <= 1'b0;
			irq_en_reg <= ST_RESET;
		end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == ADDR_CONTROL)
				enable_reg <= wb_dat_i[CTRL_ENABLE_BIT];
			if (wb_adr_i == ADDR_STATUS)
				irq_en_reg <= wb_dat_i[ST_BITS-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			irq      <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
			irq      <= |(status_reg & irq_en_reg);
			wb_dat_o <= 32'h0000_0000;
			if (wb_hit && !wb_we_i) begin
				unique case (wb_adr_i)
					ADDR_CONTROL: wb_dat_o <= {31'h0000_0000, enable_reg};
					ADDR_WIDTH:   wb_dat_o <= {8'h00, width_reg};
					ADDR_STATUS:  wb_dat_o <= {14'h0000, irq_en_reg, 14'h0000, status_reg};
					default:      wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : capture_ctrl

// [tb/capture_monitor.sv]
/*
 Checker on the register port between capture unit and controller.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module capture_monitor
	import capture_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ctrl_we,
	input wire logic [1:0]  sel_wdata,
	input wire logic [1:0]  edge_wdata,
	input wire logic        flag_rd,
	input wire logic        flag_rdata,
	input wire logic        data_rd,
	input wire logic [23:0] data_rdata
);
	logic [1:0] sel_q;
	logic [1:0] edge_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Shadow of the fields, the unit keeps them private
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_q <= SEL_NONE;
			edge_q <= EDGE_OFF;
		end else if (ctrl_we) begin
			sel_q <= sel_wdata;
			edge_q <= edge_wdata;
		end
	end
	sequence s_hit;
		flag_rd && flag_rdata;
	endsequence
	sequence s_reload;
		data_rd ##1 ctrl_we;
	endsequence
	// A capture at the clearing edge wins, so a changed stamp excuses it
	a_flag_read_clear: assert property (flag_rd |=> !flag_rdata || $changed(data_rdata))
		else $error("flag survived its read");
	a_flag_sticky: assert property (flag_rdata && !flag_rd |=> flag_rdata)
		else $error("flag lost without a read");
	a_data_read_clear: assert property (data_rd |=> data_rdata == 24'h00_0000 || flag_rdata)
		else $error("data survived its read");
	a_flag_with_data: assert property ($rose(flag_rdata) |-> $changed(data_rdata))
		else $error("flag set without a stamp");
	a_data_needs_event: assert property ($changed(data_rdata) |-> flag_rdata || data_rdata == 24'h00_0000)
		else $error("stamp changed without a capture");
	a_capture_gate: assert property ($rose(flag_rdata) |-> $past(sel_q) == SEL_RX_FIRST && $past(edge_q) != EDGE_OFF)
		else $error("capture while deselected");
	a_poll_order: assert property (s_hit |=> s_reload)
		else $error("flag hit not followed by data read and edge swap");
	// A fresh selection always starts on the falling edge, whatever edge was left behind
	a_edge_alternate: assert property (ctrl_we && sel_wdata == SEL_RX_FIRST |->
		edge_wdata == ((sel_q == SEL_RX_FIRST && edge_q == EDGE_FALLING) ? EDGE_RISING : EDGE_FALLING))
		else $error("edge select out of turn");
	a_poll_spacing: assert property (flag_rd |=> !flag_rd [*8])
		else $error("flag polled too often");
endmodule : capture_monitor

// [tb/tb.sv]
/*
 Testbench: capture unit and controller joined by their interface.
 Assumes the serial line is driven here and Wishbone and irq are the only views.
*/
`timescale 1ns/1ps
module tb;
	import capture_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rx = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] dout;
	logic [31:0] rd;
	logic        ack;
	logic        irq;
	int          mismatches = 0;
	int          comparisons = 0;
	capture_if cif();
	capture_unit capture_unit_inst (.clk(clk), .rst(rst), .serial_rx_pin_first(rx), .port_if(cif.unit));
	capture_ctrl #(.TICK(20)) capture_ctrl_inst (.clk(clk), .rst(rst), .port_if(cif.ctrl), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout),
		.wb_ack_o(ack), .irq(irq));
	capture_monitor capture_monitor_inst (.clk(clk), .rst(rst), .ctrl_we(cif.ctrl_we), .sel_wdata(cif.sel_wdata),
		.edge_wdata(cif.edge_wdata), .flag_rd(cif.flag_rd), .flag_rdata(cif.flag_rdata), .data_rd(cif.data_rd),
		.data_rdata(cif.data_rdata));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic give_verdict;
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		check("wb_dat_o", rd, e);
	endtask : rdc
	task automatic irqc(input logic e);
		repeat (3) @(negedge clk);
		check("irq", {31'h0000_0000, irq}, {31'h0000_0000, e});
	endtask : irqc
	// Long idle after each pulse: a high stretch must never be measured
	task automatic pulse(input logic [31:0] n);
		@(posedge clk);
		rx <= 1'b0;
		repeat (n) @(posedge clk);
		rx <= 1'b1;
		repeat (3000) @(posedge clk);
	endtask : pulse
	// Idle high, low start, data LSB first, two stop bits
	task automatic frame(input logic [7:0] b);
		logic [10:0] f;
		f = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx <= f[i];
			repeat (2048) @(posedge clk);
		end
		repeat (3000) @(posedge clk);
	endtask : frame
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc(ADDR_CONTROL, 32'h0000_0000);
		rdc(ADDR_WIDTH, 32'h0000_0000);
		rdc(4'h2, 32'h0000_0000);
		pulse(32'h0000_0800);
		rdc(ADDR_STATUS, 32'h0000_0000);
		wb(1'b1, ADDR_CONTROL, 32'h0000_0001);
		wb(1'b1, ADDR_STATUS, 32'h0000_0003);
		for (int k = 1; k <= 2; k++) begin
			pulse(32'(k) * 32'h0000_0800);
			rdc(ADDR_WIDTH, 32'(k) * 32'h0000_0800);
			rdc(ADDR_STATUS, 32'h0003_0001);
			irqc(1'b1);
			wb(1'b1, ADDR_CLEAR, 32'h0000_0003);
			irqc(1'b0);
		end
		// Short glitch is rejected and its irq stays masked
		wb(1'b1, ADDR_STATUS, 32'h0000_0001);
		pulse(32'h0000_0200);
		rdc(ADDR_STATUS, 32'h0001_0002);
		irqc(1'b0);
		// Whole frame: one and two bit lows, last one is a single bit
		wb(1'b1, ADDR_CLEAR, 32'h0000_0003);
		frame(8'h49);
		rdc(ADDR_WIDTH, 32'h0000_0800);
		rdc(ADDR_STATUS, 32'h0001_0001);
		irqc(1'b1);
		give_verdict();
	end
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
endmodule : tb
